// ### core/udf_core.sv
// The strobed register port and the placing of the registers are this design's own decisions.
`default_nettype none
module udf_core #(
	parameter int TICK_CYC = udf_pkg::TICK_CYCLES
) (
	// clock, reset, enable
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// terminal pins
	input wire logic run_i,
	input wire logic raise_i,
	input wire logic lower_i,
	input wire logic clear_i,
	input wire logic fault_i,
	input wire logic power_fail_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// drive side
	output logic [15:0] freq_o,
	output logic ramping_o
);
	logic [udf_pkg::PIN_W-1:0] pins, lvl;
	logic save_r, save_nxt;
	udf_pkg::udf_mode_t mode_r, mode_nxt;
	logic [15:0] maxf_r, maxf_nxt, stepf_r, stepf_nxt;
	logic [15:0] accs_r, accs_nxt, decs_r, decs_nxt;
	logic [15:0] freq_r, freq_nxt, saved_r, saved_nxt;
	logic svalid_r, svalid_nxt, fb_r, fb_nxt;
	logic active_r, const_r, const_nxt;
	logic raise_r, lower_r, clear_r;
	logic [11:0] hold_r, hold_nxt;
	logic [15:0] tick_r, tick_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic ramp_r;
	logic active, up, dn, tick, norm_eff, step_eff, ramp;
	logic raise_rise, lower_rise, clr_rise;
	logic [16:0] sum_up, sum_step;
	logic [15:0] f_up, f_dn, f_sup, f_sdn;

	localparam logic [11:0] HOLD_LAST = udf_pkg::HOLD_TICKS - 12'h001;

	assign pins = {power_fail_i, fault_i, clear_i, lower_i, raise_i, run_i};

	udf_pin_sync #(.W(udf_pkg::PIN_W)) u_sync (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.pin_i(pins),
		.lvl_o(lvl)
	);

	assign active = lvl[udf_pkg::PIN_RUN] & ~lvl[udf_pkg::PIN_FAULT] &
		~lvl[udf_pkg::PIN_PWRF];
	assign up = lvl[udf_pkg::PIN_RAISE] & ~lvl[udf_pkg::PIN_LOWER];
	assign dn = lvl[udf_pkg::PIN_LOWER] & ~lvl[udf_pkg::PIN_RAISE];
	assign raise_rise = lvl[udf_pkg::PIN_RAISE] & ~raise_r;
	assign lower_rise = lvl[udf_pkg::PIN_LOWER] & ~lower_r;
	assign clr_rise = lvl[udf_pkg::PIN_CLEAR] & ~clear_r;
	assign tick = (tick_r == 16'(TICK_CYC - 1));
	assign norm_eff = (mode_r == udf_pkg::UDF_NORMAL) ||
		(mode_r == udf_pkg::UDF_STEP_NORM && fb_r);
	assign step_eff = !norm_eff;
	assign ramp = active & active_r & norm_eff & (up | dn);

	// saturating arithmetic keeps the command inside 0..max
	assign sum_up = {1'b0, freq_r} + {1'b0, accs_r};
	assign sum_step = {1'b0, freq_r} + {1'b0, stepf_r};
	assign f_up = (sum_up > {1'b0, maxf_r}) ? maxf_r : sum_up[15:0];
	assign f_sup = (sum_step > {1'b0, maxf_r}) ? maxf_r : sum_step[15:0];
	assign f_dn = (freq_r > decs_r) ? freq_r - decs_r : 16'h0000;
	assign f_sdn = (freq_r > stepf_r) ? freq_r - stepf_r : 16'h0000;

	always_comb begin
		tick_nxt = tick ? 16'h0000 : tick_r + 16'h0001;
		freq_nxt = freq_r;
		saved_nxt = saved_r;
		svalid_nxt = svalid_r;
		fb_nxt = fb_r;
		hold_nxt = hold_r;
		if (active && !active_r) begin
			// resume only from a valid save
			freq_nxt = (save_r && svalid_r) ? saved_r : 16'h0000;
		end else if (!active && active_r) begin
			freq_nxt = 16'h0000;
			if (save_r && const_r) begin
				saved_nxt = freq_r;
				svalid_nxt = 1'b1;
			end
		end else if (!active) begin
			freq_nxt = 16'h0000;
		end else if (clr_rise && const_r) begin
			saved_nxt = 16'h0000;
			svalid_nxt = 1'b0;
			fb_nxt = 1'b0;
			hold_nxt = 12'h000;
			freq_nxt = 16'h0000;
		end else if (norm_eff) begin
			// both inputs or none: hold constant
			if (tick && up) begin
				freq_nxt = f_up;
			end else if (tick && dn) begin
				freq_nxt = f_dn;
			end
		end else begin
			if (raise_rise && !lvl[udf_pkg::PIN_LOWER]) begin
				freq_nxt = f_sup;
			end else if (lower_rise && !lvl[udf_pkg::PIN_RAISE]) begin
				freq_nxt = f_sdn;
			end
		end
		if (mode_r == udf_pkg::UDF_STEP_NORM && active && (up || dn)) begin
			if (tick && !fb_r) begin
				if (hold_r == HOLD_LAST) begin
					fb_nxt = 1'b1;
				end else begin
					hold_nxt = hold_r + 12'h001;
				end
			end
		end else begin
			hold_nxt = 12'h000;
			fb_nxt = 1'b0;
		end
		// a lowered maximum pulls the command down at once
		if (freq_nxt > maxf_r) begin
			freq_nxt = maxf_r;
		end
		const_nxt = active & ~ramp;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_r <= 16'h0000;
			freq_r <= 16'h0000;
			saved_r <= 16'h0000;
			svalid_r <= 1'b0;
			fb_r <= 1'b0;
			hold_r <= 12'h000;
			active_r <= 1'b0;
			const_r <= 1'b0;
			ramp_r <= 1'b0;
			raise_r <= 1'b0;
			lower_r <= 1'b0;
			clear_r <= 1'b0;
		end else if (ce_i) begin
			tick_r <= tick_nxt;
			freq_r <= freq_nxt;
			saved_r <= saved_nxt;
			svalid_r <= svalid_nxt;
			fb_r <= fb_nxt;
			hold_r <= hold_nxt;
			active_r <= active;
			const_r <= const_nxt;
			ramp_r <= ramp;
			raise_r <= lvl[udf_pkg::PIN_RAISE];
			lower_r <= lvl[udf_pkg::PIN_LOWER];
			clear_r <= lvl[udf_pkg::PIN_CLEAR];
		end
	end

	// register port: read data stand the cycle after the strobe
	always_comb begin
		save_nxt = save_r;
		mode_nxt = mode_r;
		maxf_nxt = maxf_r;
		stepf_nxt = stepf_r;
		accs_nxt = accs_r;
		decs_nxt = decs_r;
		rdata_nxt = 32'h00000000;
		if (wr_i) begin
			unique case (addr_i)
				udf_pkg::OFS_CTRL: begin
					save_nxt = wdata_i[udf_pkg::CTRL_SAVE_BIT];
					// code 3 is outside the range and is ignored
					if (wdata_i[udf_pkg::CTRL_MODE_MSB:udf_pkg::CTRL_MODE_LSB]
						!= 2'b11) begin
						mode_nxt = udf_pkg::udf_mode_t'(
							wdata_i[udf_pkg::CTRL_MODE_MSB:
							udf_pkg::CTRL_MODE_LSB]);
					end
				end
				udf_pkg::OFS_MAXF: maxf_nxt = wdata_i[15:0];
				udf_pkg::OFS_STEPF: stepf_nxt = wdata_i[15:0];
				udf_pkg::OFS_ACCS: accs_nxt = wdata_i[15:0];
				udf_pkg::OFS_DECS: decs_nxt = wdata_i[15:0];
				default: ;
			endcase
		end
		if (rd_i) begin
			unique case (addr_i)
				udf_pkg::OFS_CTRL: rdata_nxt = {29'h00000000, mode_r, save_r};
				udf_pkg::OFS_MAXF: rdata_nxt = {16'h0000, maxf_r};
				udf_pkg::OFS_STEPF: rdata_nxt = {16'h0000, stepf_r};
				udf_pkg::OFS_ACCS: rdata_nxt = {16'h0000, accs_r};
				udf_pkg::OFS_DECS: rdata_nxt = {16'h0000, decs_r};
				udf_pkg::OFS_FREQ: rdata_nxt = {16'h0000, freq_r};
				udf_pkg::OFS_SAVED: rdata_nxt = {16'h0000, saved_r};
				udf_pkg::OFS_STAT: rdata_nxt = {28'h0000000, fb_r, svalid_r,
					const_r, active_r};
				default: rdata_nxt = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			save_r <= udf_pkg::RST_SAVE;
			mode_r <= udf_pkg::UDF_NORMAL;
			maxf_r <= udf_pkg::RST_MAXF;
			stepf_r <= udf_pkg::RST_STEPF;
			accs_r <= udf_pkg::RST_ACCS;
			decs_r <= udf_pkg::RST_DECS;
			rdata_r <= 32'h00000000;
		end else if (ce_i) begin
			save_r <= save_nxt;
			mode_r <= mode_nxt;
			maxf_r <= maxf_nxt;
			stepf_r <= stepf_nxt;
			accs_r <= accs_nxt;
			decs_r <= decs_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata_o = rdata_r;
	assign freq_o = freq_r;
	assign ramping_o = ramp_r;

	logic steady;
	assign steady = ce_i && active && active_r && !wr_i && !clr_rise;

	property p_accel;
		@(posedge mclk_i) disable iff (rst_i)
		steady && norm_eff && tick && up && freq_r < maxf_r && accs_r != 0
		|=> freq_r > $past(freq_r);
	endproperty
	a_accel: assert property (p_accel) else $error("no acceleration");

	property p_hold_release;
		@(posedge mclk_i) disable iff (rst_i)
		steady && !lvl[udf_pkg::PIN_RAISE] && !lvl[udf_pkg::PIN_LOWER] &&
		freq_r <= maxf_r |=> $stable(freq_r);
	endproperty
	a_hold_release: assert property (p_hold_release)
		else $error("frequency moved with no input");

	property p_decel;
		@(posedge mclk_i) disable iff (rst_i)
		steady && norm_eff && tick && dn && freq_r != 0 && decs_r != 0 &&
		freq_r <= maxf_r |=> freq_r < $past(freq_r);
	endproperty
	a_decel: assert property (p_decel) else $error("no deceleration");

	property p_both;
		@(posedge mclk_i) disable iff (rst_i)
		steady && lvl[udf_pkg::PIN_RAISE] && lvl[udf_pkg::PIN_LOWER] &&
		freq_r <= maxf_r |=> $stable(freq_r) && !ramping_o;
	endproperty
	a_both: assert property (p_both) else $error("ramp with both inputs");

	property p_nosave;
		@(posedge mclk_i) disable iff (rst_i)
		ce_i && !save_r && active_r && !active |=> $stable(svalid_r) &&
		$stable(saved_r);
	endproperty
	a_nosave: assert property (p_nosave) else $error("saved while off");

	property p_save;
		@(posedge mclk_i) disable iff (rst_i)
		ce_i && save_r && const_r && active_r && !active |=> svalid_r &&
		saved_r == $past(freq_r) && freq_r == 0;
	endproperty
	a_save: assert property (p_save) else $error("frequency not stored");

	property p_resume;
		@(posedge mclk_i) disable iff (rst_i)
		ce_i && save_r && svalid_r && !active_r && active &&
		saved_r <= maxf_r |=> freq_r == $past(saved_r);
	endproperty
	a_resume: assert property (p_resume) else $error("no resume");

	property p_clear;
		@(posedge mclk_i) disable iff (rst_i)
		ce_i && active && active_r && clr_rise && const_r
		|=> !svalid_r && saved_r == 0 && freq_r == 0 && !fb_r;
	endproperty
	a_clear: assert property (p_clear) else $error("clear ignored");

	property p_mode;
		@(posedge mclk_i) disable iff (rst_i)
		mode_r != 2'b11;
	endproperty
	a_mode: assert property (p_mode) else $error("illegal sub-mode");

	property p_step;
		@(posedge mclk_i) disable iff (rst_i)
		steady && step_eff && raise_rise && !lvl[udf_pkg::PIN_LOWER] &&
		sum_step <= {1'b0, maxf_r} |=> freq_r == $past(sum_step[15:0]);
	endproperty
	a_step: assert property (p_step) else $error("wrong step");

	property p_fallback;
		@(posedge mclk_i) disable iff (rst_i)
		ce_i && mode_r == udf_pkg::UDF_STEP_NORM && active && (up || dn) &&
		tick && !fb_r && hold_r == HOLD_LAST |=> fb_r;
	endproperty
	a_fallback: assert property (p_fallback) else $error("no fallback");

	property p_range;
		@(posedge mclk_i) disable iff (rst_i)
		$stable(maxf_r) |-> freq_r <= maxf_r;
	endproperty
	a_range: assert property (p_range) else $error("above maximum");

	c_at_max: cover property (@(posedge mclk_i) disable iff (rst_i)
		active && freq_r == maxf_r && up);
	c_fallback: cover property (@(posedge mclk_i) disable iff (rst_i)
		$rose(fb_r));
	c_resume: cover property (@(posedge mclk_i) disable iff (rst_i)
		svalid_r && $rose(active_r) && save_r);
	c_clear: cover property (@(posedge mclk_i) disable iff (rst_i)
		$fell(svalid_r));
endmodule
`default_nettype wire

// ### core/udf_pkg.sv
`default_nettype none
package udf_pkg;
	localparam int FREQ_W = 16;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int PIN_W = 6;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MAXF = 8'h04;
	localparam logic [7:0] OFS_STEPF = 8'h08;
	localparam logic [7:0] OFS_ACCS = 8'h0c;
	localparam logic [7:0] OFS_DECS = 8'h10;
	localparam logic [7:0] OFS_FREQ = 8'h14;
	localparam logic [7:0] OFS_SAVED = 8'h18;
	localparam logic [7:0] OFS_STAT = 8'h1c;
	// control fields
	localparam int CTRL_SAVE_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_MODE_MSB = 2;
	// status fields
	localparam int STAT_ACTIVE_BIT = 0;
	localparam int STAT_CONST_BIT = 1;
	localparam int STAT_SVALID_BIT = 2;
	localparam int STAT_FALLBK_BIT = 3;
	// pin vector positions
	localparam int PIN_RUN = 0;
	localparam int PIN_RAISE = 1;
	localparam int PIN_LOWER = 2;
	localparam int PIN_CLEAR = 3;
	localparam int PIN_FAULT = 4;
	localparam int PIN_PWRF = 5;
	// values after reset, frequency in 0.01 Hz
	localparam logic [15:0] RST_MAXF = 16'h1770;
	localparam logic [15:0] RST_STEPF = 16'h0000;
	localparam logic [15:0] RST_ACCS = 16'h0001;
	localparam logic [15:0] RST_DECS = 16'h0001;
	localparam logic RST_SAVE = 1'b1;
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int HOLD_MS = 3000;
	localparam int TICK_MS = 1;
	localparam logic [11:0] HOLD_TICKS = 12'(HOLD_MS / TICK_MS);
	typedef enum logic [1:0] {
		UDF_NORMAL = 2'b00,
		UDF_STEP = 2'b01,
		UDF_STEP_NORM = 2'b10
	} udf_mode_t;
endpackage
`default_nettype wire

// ### core/udf_pin_sync.sv
`default_nettype none
module udf_pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// pins and filtered levels
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] lvl_o
);
	logic [W-1:0] s1_r, s2_r, s3_r, lvl_r;
	logic [W-1:0] lvl_nxt;

	// take the new level only where stages two and three agree
	always_comb begin
		lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			lvl_r <= '0;
		end else if (ce_i) begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	assign lvl_o = lvl_r;
endmodule
`default_nettype wire

// ### tb/udf_switch_model.sv
`default_nettype none
module udf_switch_model (
	// clock the contacts are updated on
	input wire logic mclk_i,
	// contacts toward the drive terminals
	output logic run_o,
	output logic raise_o,
	output logic lower_o,
	output logic clear_o,
	output logic fault_o,
	output logic power_fail_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// one contact per function: raise as code 17, lower 18, clear 20
	logic [5:0] pins_r = 6'h00;
	assign run_o = pins_r[udf_pkg::PIN_RUN];
	assign raise_o = pins_r[udf_pkg::PIN_RAISE];
	assign lower_o = pins_r[udf_pkg::PIN_LOWER];
	assign clear_o = pins_r[udf_pkg::PIN_CLEAR];
	assign fault_o = pins_r[udf_pkg::PIN_FAULT];
	assign power_fail_o = pins_r[udf_pkg::PIN_PWRF];
	// slow contact: two one-cycle bounces before settling, as a worn button
	task automatic put(input int idx, input logic val, input bit bounce);
		if (bounce) begin
			repeat (2) begin
				@(posedge mclk_i);
				pins_r[idx] <= val;
				@(posedge mclk_i);
				pins_r[idx] <= !val;
			end
		end
		@(posedge mclk_i);
		pins_r[idx] <= val;
	endtask
endmodule
`default_nettype wire

// ### tb/up_down_frequency_control_tb.sv
`default_nettype none
module up_down_frequency_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// short tick keeps the 3000-tick fallback near 12000 cycles
	localparam int TCYC = 4;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic ce = 1'b1;
	logic [31:0] rdata_o;
	logic [15:0] freq_o;
	logic ramping_o;
	logic run, raise, lower, clear, fault, pwrf;
	int fails = 0;
	int n_compared = 0;
	logic [31:0] rv;
	logic [15:0] v;
	logic [7:0] ofs [8] = '{udf_pkg::OFS_CTRL, udf_pkg::OFS_MAXF,
		udf_pkg::OFS_STEPF, udf_pkg::OFS_ACCS, udf_pkg::OFS_DECS,
		udf_pkg::OFS_FREQ, udf_pkg::OFS_SAVED, udf_pkg::OFS_STAT};
	logic [31:0] rst_v [8] = '{32'(udf_pkg::RST_SAVE), 32'(udf_pkg::RST_MAXF),
		32'(udf_pkg::RST_STEPF), 32'(udf_pkg::RST_ACCS),
		32'(udf_pkg::RST_DECS), 32'h0, 32'h0, 32'h0};
	always #10 mclk_i = ~mclk_i;
	udf_switch_model sw (.mclk_i(mclk_i), .run_o(run), .raise_o(raise),
		.lower_o(lower), .clear_o(clear), .fault_o(fault),
		.power_fail_o(pwrf));
	udf_core #(.TICK_CYC(TCYC)) uut (.mclk_i(mclk_i), .rst_i(rst_i),
		.ce_i(ce), .run_i(run), .raise_i(raise), .lower_i(lower),
		.clear_i(clear), .fault_i(fault), .power_fail_i(pwrf),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .freq_o(freq_o), .ramping_o(ramping_o));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk(d, exp);
	endtask
	task automatic stat_bit(input int b, input logic exp);
		logic [31:0] d;
		rd(udf_pkg::OFS_STAT, d);
		chk(32'(d[b]), 32'(exp));
	endtask
	task automatic wait_freq(input logic [15:0] exp, input int lim);
		int k;
		k = 0;
		// step off the edge so the freshly launched value is seen
		#1;
		while (freq_o !== exp && k < lim) begin
			cyc(1);
			k++;
		end
		chk(32'(freq_o), 32'(exp));
	endtask
	task automatic press(input int idx, input int n, input bit bnc);
		sw.put(idx, 1'b1, bnc);
		cyc(n);
		sw.put(idx, 1'b0, 1'b0);
		cyc(10);
	endtask
	initial begin
		repeat (100000) @(posedge mclk_i);
		fails++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge mclk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) rdchk(ofs[i], rst_v[i]);
		rdchk(8'h20, 32'h0);
		wr(8'h20, 32'h0000_00ff);
		rdchk(8'h20, 32'h0);
		wr(udf_pkg::OFS_FREQ, 32'h0000_ffff);
		rdchk(udf_pkg::OFS_FREQ, 32'h0);
		wr(udf_pkg::OFS_CTRL, 32'h0);
		wr(udf_pkg::OFS_ACCS, 32'h3);
		wr(udf_pkg::OFS_DECS, 32'h5);
		sw.put(udf_pkg::PIN_RUN, 1'b1, 1'b0);
		sw.put(udf_pkg::PIN_RAISE, 1'b1, 1'b1);
		cyc(40);
		chk(32'(ramping_o), 32'h1);
		sw.put(udf_pkg::PIN_RAISE, 1'b0, 1'b0);
		cyc(10);
		v = freq_o;
		cyc(40);
		chk(32'(freq_o), 32'(v));
		chk(32'(v != 16'h0000), 32'h1);
		stat_bit(udf_pkg::STAT_ACTIVE_BIT, 1'b1);
		stat_bit(udf_pkg::STAT_CONST_BIT, 1'b1);
		wr(udf_pkg::OFS_MAXF, 32'h10);
		sw.put(udf_pkg::PIN_RAISE, 1'b1, 1'b0);
		wait_freq(16'h0010, 200);
		sw.put(udf_pkg::PIN_RAISE, 1'b0, 1'b0);
		press(udf_pkg::PIN_LOWER, 100, 1'b0);
		wait_freq(16'h0000, 50);
		sw.put(udf_pkg::PIN_RAISE, 1'b1, 1'b0);
		cyc(16);
		sw.put(udf_pkg::PIN_LOWER, 1'b1, 1'b0);
		cyc(8);
		v = freq_o;
		cyc(40);
		chk(32'(freq_o), 32'(v));
		chk(32'(ramping_o), 32'h0);
		sw.put(udf_pkg::PIN_RAISE, 1'b0, 1'b0);
		sw.put(udf_pkg::PIN_LOWER, 1'b0, 1'b0);
		cyc(10);
		wr(udf_pkg::OFS_MAXF, 32'h100);
		wr(udf_pkg::OFS_STEPF, 32'h2);
		wr(udf_pkg::OFS_CTRL, 32'h2);
		v = freq_o;
		for (int i = 0; i < 3; i++) press(udf_pkg::PIN_RAISE, 50, i == 0);
		wait_freq(v + 16'h0006, 20);
		press(udf_pkg::PIN_LOWER, 20, 1'b0);
		wait_freq(v + 16'h0004, 20);
		wr(udf_pkg::OFS_CTRL, 32'h7);
		rdchk(udf_pkg::OFS_CTRL, 32'h3);
		wr(udf_pkg::OFS_CTRL, 32'h4);
		sw.put(udf_pkg::PIN_RAISE, 1'b1, 1'b0);
		cyc(11000);
		chk(32'(freq_o), 32'(v + 16'h0006));
		stat_bit(udf_pkg::STAT_FALLBK_BIT, 1'b0);
		wait_freq(16'h0100, 2000);
		stat_bit(udf_pkg::STAT_FALLBK_BIT, 1'b1);
		sw.put(udf_pkg::PIN_RAISE, 1'b0, 1'b0);
		cyc(10);
		stat_bit(udf_pkg::STAT_FALLBK_BIT, 1'b0);
		wr(udf_pkg::OFS_CTRL, 32'h1);
		cyc(4);
		sw.put(udf_pkg::PIN_RUN, 1'b0, 1'b0);
		wait_freq(16'h0000, 50);
		rdchk(udf_pkg::OFS_SAVED, 32'h100);
		stat_bit(udf_pkg::STAT_SVALID_BIT, 1'b1);
		sw.put(udf_pkg::PIN_RUN, 1'b1, 1'b0);
		wait_freq(16'h0100, 50);
		for (int i = udf_pkg::PIN_FAULT; i <= udf_pkg::PIN_PWRF; i++) begin
			sw.put(i, 1'b1, 1'b0);
			wait_freq(16'h0000, 50);
			sw.put(i, 1'b0, 1'b0);
			wait_freq(16'h0100, 50);
		end
		press(udf_pkg::PIN_CLEAR, 10, 1'b0);
		wait_freq(16'h0000, 50);
		rdchk(udf_pkg::OFS_SAVED, 32'h0);
		stat_bit(udf_pkg::STAT_SVALID_BIT, 1'b0);
		sw.put(udf_pkg::PIN_RUN, 1'b0, 1'b0);
		cyc(20);
		sw.put(udf_pkg::PIN_RUN, 1'b1, 1'b0);
		cyc(20);
		chk(32'(freq_o), 32'h0);
		wr(udf_pkg::OFS_CTRL, 32'h0);
		rdchk(udf_pkg::OFS_CTRL, 32'h0);
		sw.put(udf_pkg::PIN_RAISE, 1'b1, 1'b0);
		cyc(20);
		// clock enable low must freeze the ramp mid-way
		@(posedge mclk_i);
		ce <= 1'b0;
		cyc(1);
		v = freq_o;
		cyc(40);
		chk(32'(freq_o), 32'(v));
		chk(32'(v < 16'h0100), 32'h1);
		@(posedge mclk_i);
		ce <= 1'b1;
		wait_freq(16'h0100, 1000);
		sw.put(udf_pkg::PIN_RAISE, 1'b0, 1'b0);
		cyc(10);
		sw.put(udf_pkg::PIN_RUN, 1'b0, 1'b0);
		cyc(20);
		sw.put(udf_pkg::PIN_RUN, 1'b1, 1'b0);
		cyc(20);
		chk(32'(freq_o), 32'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
